/* File: core/dmsd_pkg.sv */
// Constants shared by the dual-modulus synthesizer divider design
package dmsd_pkg;
    // Register byte addresses on the APB
    localparam logic [7:0] OFF_PORT = 8'h00;
    localparam logic [7:0] OFF_LATCH = 8'h04;
    localparam logic [7:0] OFF_PROG = 8'h08;
    // Field positions of the port register
    localparam int STROBE_BIT = 7;
    localparam int LOAD_GATE_BIT = 8;
    // Nibble select codes inside the divider core
    localparam logic [2:0] SEL_REF_LO = 3'h0;
    localparam logic [2:0] SEL_REF_HI = 3'h1;
    localparam logic [2:0] SEL_COARSE_LO = 3'h2;
    localparam logic [2:0] SEL_COARSE_HI = 3'h3;
    localparam logic [2:0] SEL_FINE_LO = 3'h4;
    localparam logic [2:0] SEL_FINE_HI = 3'h5;
    localparam logic [2:0] SEL_AUX = 3'h6;
    // Values after reset
    localparam logic [7:0] REF_DIV_RST = 8'h64;
    localparam logic [7:0] COARSE_RST = 8'h3B;
    localparam logic [7:0] FINE_RST = 8'h00;
    localparam logic [3:0] AUX_RST = 4'h0;
    localparam logic [8:0] PORT_RST = 9'h080;
    // Prescaler counts
    localparam logic [3:0] MOD_SHORT = 4'hA;
    localparam logic [3:0] MOD_LONG = 4'hB;
    localparam logic [2:0] QUIN_LAST = 3'h4;
    localparam int PRES_SHORT = 50;
    localparam int PRES_LONG = 51;
    // Auxiliary output choices
    typedef enum logic [1:0] {
        AUX_REF, AUX_PRES, AUX_COMP, AUX_MODCTL
    } dmsd_aux_t;
endpackage : dmsd_pkg

/* File: core/dmsd_chain_if.sv */
// Signals of the divider chain between prescaler and counters
`timescale 1ns/1ps
`default_nettype none
interface dmsd_chain_if;
    logic oscEdge;
    logic presPulse;
    logic quinaryTop;
    logic quinarySecond;
    logic halfStageOut;
    logic modulusControl;
    logic compPulse;
    modport pre (
        input oscEdge, modulusControl,
        output presPulse, quinaryTop, quinarySecond, halfStageOut
    );
    modport cnt (
        input presPulse,
        output modulusControl, compPulse
    );
    modport top (
        input presPulse, quinaryTop, quinarySecond, halfStageOut,
        input modulusControl, compPulse,
        output oscEdge
    );
endinterface : dmsd_chain_if
`default_nettype wire

/* File: core/dmsd_prescaler.sv */
// Two-modulus stage plus divide-by-5 stage: a 50/51 prescaler
`timescale 1ns/1ps
`default_nettype none
module dmsd_prescaler
    import dmsd_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic nrst, // Asynchronous reset, active low
    dmsd_chain_if.pre chain // Divider chain signals
);
    logic [3:0] tmCnt_reg, tmCnt_next;
    logic [3:0] modLen_reg, modLen_next;
    logic [2:0] quinCnt_reg, quinCnt_next;
    logic half_reg, half_next;
    logic pres_reg, pres_next;
    logic periodEnd;
    logic enableA, enableB;

    assign enableA = chain.modulusControl;
    assign enableB = (quinCnt_reg != QUIN_LAST);
    assign periodEnd = chain.oscEdge && (tmCnt_reg == modLen_reg - 4'h1);

    always_comb begin
        tmCnt_next = tmCnt_reg;
        modLen_next = modLen_reg;
        quinCnt_next = quinCnt_reg;
        if (chain.oscEdge) begin
            tmCnt_next = tmCnt_reg + 4'h1;
        end
        if (periodEnd) begin
            tmCnt_next = 4'h0;
            // Enables only matter at the output edge
            modLen_next = (enableA || enableB) ? MOD_SHORT : MOD_LONG;
            quinCnt_next = (quinCnt_reg == QUIN_LAST) ? 3'h0 :
                quinCnt_reg + 3'h1;
        end
        // High while count bits 2 and 1 are both clear: 2 of 5 high
        half_next = (quinCnt_next[2:1] == 2'h0);
        pres_next = half_next && !half_reg;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tmCnt_reg <= 4'h0;
            modLen_reg <= MOD_SHORT;
            quinCnt_reg <= 3'h0;
            half_reg <= 1'b1;
            pres_reg <= 1'b0;
        end else begin
            tmCnt_reg <= tmCnt_next;
            modLen_reg <= modLen_next;
            quinCnt_reg <= quinCnt_next;
            half_reg <= half_next;
            pres_reg <= pres_next;
        end
    end

    assign chain.presPulse = pres_reg;
    assign chain.quinaryTop = enableB;
    assign chain.quinarySecond = quinCnt_reg[1];
    assign chain.halfStageOut = half_reg;

    // Helper: oscillator edges between prescaler pulses
    logic [6:0] oscSeen;
    logic seenPulse;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oscSeen <= 7'h0;
            seenPulse <= 1'b0;
        end else if (pres_reg) begin
            oscSeen <= chain.oscEdge ? 7'h1 : 7'h0;
            seenPulse <= 1'b1;
        end else if (chain.oscEdge) begin
            oscSeen <= oscSeen + 7'h1;
        end
    end

    a_pres_ratio: assert property (@(posedge clk) disable iff (!nrst)
        (pres_reg && seenPulse && !chain.oscEdge) |->
            (oscSeen == 7'(PRES_SHORT) || oscSeen == 7'(PRES_LONG)))
        else $error("prescaler ratio is not 50 or 51");
    a_mod_select: assert property (@(posedge clk) disable iff (!nrst)
        periodEnd |=> (modLen_reg == MOD_LONG) ==
            (!$past(enableA) && !$past(enableB)))
        else $error("two-modulus stage chose wrong modulus");
    a_quin_top: assert property (@(posedge clk) disable iff (!nrst)
        (periodEnd && quinCnt_reg == QUIN_LAST) |=> enableB)
        else $error("quinary top bit stayed low too long");
endmodule : dmsd_prescaler
`default_nettype wire

/* File: core/dmsd_modcount.sv */
// Coarse and fine counters that drive modulus control
`timescale 1ns/1ps
`default_nettype none
module dmsd_modcount
    import dmsd_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic [7:0] coarseCount, // Programmed coarse count
    input wire logic [7:0] fineCount, // Programmed fine count
    dmsd_chain_if.cnt chain // Divider chain signals
);
    logic [7:0] cnt_reg, cnt_next;
    logic mc_reg, mc_next;
    logic comp_reg, comp_next;

    always_comb begin
        cnt_next = cnt_reg;
        comp_next = 1'b0;
        if (chain.presPulse) begin
            // A divisor changed below the count wraps at the next prescaler pulse
            if (cnt_reg >= coarseCount - 8'h1) begin
                cnt_next = 8'h0;
                comp_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 8'h1;
            end
        end
        mc_next = (cnt_next >= fineCount);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 8'h0;
            mc_reg <= 1'b1;
            comp_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            mc_reg <= mc_next;
            comp_reg <= comp_next;
        end
    end

    assign chain.modulusControl = mc_reg;
    assign chain.compPulse = comp_reg;

    // Helper: prescaler cycles in each comparison period
    logic [7:0] presSeen;
    logic [7:0] lowSeen;
    logic seenComp;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            presSeen <= 8'h0;
            lowSeen <= 8'h0;
            seenComp <= 1'b0;
        end else if (comp_reg) begin
            presSeen <= 8'h0;
            lowSeen <= 8'h0;
            seenComp <= 1'b1;
        end else if (chain.presPulse) begin
            presSeen <= presSeen + 8'h1;
            lowSeen <= lowSeen + {7'h0, !mc_reg};
        end
    end

    // Helper: a period is judged only if no divisor moved inside it
    logic [7:0] coarsePrev, finePrev;
    logic cfgMoved, cfgQuiet;
    assign cfgMoved = (coarseCount != coarsePrev) || (fineCount != finePrev);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            coarsePrev <= COARSE_RST;
            finePrev <= FINE_RST;
            cfgQuiet <= 1'b0;
        end else begin
            coarsePrev <= coarseCount;
            finePrev <= fineCount;
            if (comp_reg || cfgMoved) begin
                cfgQuiet <= !cfgMoved;
            end
        end
    end

    a_coarse_period: assert property (@(posedge clk) disable iff (!nrst)
        (comp_reg && seenComp && cfgQuiet && $stable(coarseCount)) |->
            (presSeen == coarseCount))
        else $error("coarse period differs from coarse count");
    a_fine_low: assert property (@(posedge clk) disable iff (!nrst)
        (comp_reg && seenComp && cfgQuiet && $stable(fineCount)) |->
            (lowSeen == fineCount))
        else $error("modulus control low count differs from fine count");
endmodule : dmsd_modcount
`default_nettype wire

/* File: core/dmsd_synth_divider.sv */
// Top of the dual-modulus synthesizer divider, programmed over APB
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module dmsd_synth_divider
    import dmsd_pkg::*;
(
    input wire logic clk, // System clock, 40 MHz
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic oscIn, // Oscillator signal, sampled
    input wire logic ref10mIn, // 10 MHz reference, sampled
    output logic [3:0] nibbleLines, // Latched nibble data
    output logic [2:0] nibbleSelect, // Latched nibble select
    output logic nibbleStrobe, // Latched strobe
    output logic modulusControl, // High: divide by 50
    output logic halfStageOut, // Prescaler rate, 40/60 duty
    output logic refPulse, // One pulse per divided reference period
    output logic divPulse, // One pulse per divided period
    output logic auxOut // Selected test signal
);
    dmsd_chain_if chain ();

    function automatic logic rising(input logic cur, input logic prev);
        rising = cur && !prev;
    endfunction : rising

    // APB slave, no wait state: answer from flops in the first access cycle
    logic [8:0] port_reg, port_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic setupPhase, accessDone, mapped;
    logic [7:0] latch_reg, latch_next;
    logic strobePrev_reg, strobePrev_next;
    logic [3:0] prog_reg [0:7];
    logic [3:0] prog_next [0:7];
    logic [7:0] refDiv, coarseCount, fineCount;

    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && pready_reg;
    assign mapped = (paddr == OFF_PORT) || (paddr == OFF_LATCH) ||
        (paddr == OFF_PROG);

    always_comb begin
        pready_next = setupPhase;
        pslverr_next = setupPhase && !mapped;
        prdata_next = prdata_reg;
        port_next = port_reg;
        if (setupPhase) begin
            case (paddr)
                OFF_PORT: prdata_next = {23'h0, port_reg};
                OFF_LATCH: prdata_next = {20'h0, chain.quinaryTop,
                    chain.halfStageOut, chain.modulusControl,
                    strobePrev_reg, latch_reg};
                OFF_PROG: prdata_next = {4'h0, prog_reg[SEL_AUX],
                    fineCount, coarseCount, refDiv};
                default: prdata_next = 32'h0;
            endcase
        end
        // Write lands only at the completing edge
        if (accessDone && pwrite && paddr == OFF_PORT) begin
            port_next = pwdata[8:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_reg <= PORT_RST;
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            port_reg <= port_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // Input latch and divider core programming
    always_comb begin
        latch_next = latch_reg;
        if (port_reg[LOAD_GATE_BIT]) begin
            latch_next = port_reg[7:0];
        end
        strobePrev_next = latch_reg[STROBE_BIT];
        for (int i = 0; i < 8; i++) begin
            prog_next[i] = prog_reg[i];
        end
        // Nibble is taken with the data present at the strobe fall
        if (strobePrev_reg && !latch_reg[STROBE_BIT]) begin
            prog_next[latch_reg[6:4]] = latch_reg[3:0];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            latch_reg <= PORT_RST[7:0];
            strobePrev_reg <= 1'b1;
            prog_reg[SEL_REF_LO] <= REF_DIV_RST[3:0];
            prog_reg[SEL_REF_HI] <= REF_DIV_RST[7:4];
            prog_reg[SEL_COARSE_LO] <= COARSE_RST[3:0];
            prog_reg[SEL_COARSE_HI] <= COARSE_RST[7:4];
            prog_reg[SEL_FINE_LO] <= FINE_RST[3:0];
            prog_reg[SEL_FINE_HI] <= FINE_RST[7:4];
            prog_reg[SEL_AUX] <= AUX_RST;
            prog_reg[3'h7] <= 4'h0;
        end else begin
            latch_reg <= latch_next;
            strobePrev_reg <= strobePrev_next;
            for (int i = 0; i < 8; i++) begin
                prog_reg[i] <= prog_next[i];
            end
        end
    end

    assign refDiv = {prog_reg[SEL_REF_HI], prog_reg[SEL_REF_LO]};
    assign coarseCount = {prog_reg[SEL_COARSE_HI], prog_reg[SEL_COARSE_LO]};
    assign fineCount = {prog_reg[SEL_FINE_HI], prog_reg[SEL_FINE_LO]};

    // Reference divider and edge sampling of the two fast inputs
    logic oscPrev_reg, refPrev_reg;
    logic oscEdge_reg, oscEdge_next;
    logic refEdge;
    logic [7:0] refCnt_reg, refCnt_next;
    logic refPulse_reg, refPulse_next;

    assign refEdge = rising(ref10mIn, refPrev_reg);

    always_comb begin
        oscEdge_next = rising(oscIn, oscPrev_reg);
        refCnt_next = refCnt_reg;
        refPulse_next = 1'b0;
        if (refEdge) begin
            // Divisor of zero is treated as one instead of hanging
            if (refCnt_reg >= refDiv - 8'h1 || refDiv == 8'h0) begin
                refCnt_next = 8'h0;
                refPulse_next = 1'b1;
            end else begin
                refCnt_next = refCnt_reg + 8'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oscPrev_reg <= 1'b0;
            refPrev_reg <= 1'b0;
            oscEdge_reg <= 1'b0;
            refCnt_reg <= 8'h0;
            refPulse_reg <= 1'b0;
        end else begin
            oscPrev_reg <= oscIn;
            refPrev_reg <= ref10mIn;
            oscEdge_reg <= oscEdge_next;
            refCnt_reg <= refCnt_next;
            refPulse_reg <= refPulse_next;
        end
    end

    assign chain.oscEdge = oscEdge_reg;

    dmsd_prescaler u_prescaler (
        .clk(clk),
        .nrst(nrst),
        .chain(chain.pre)
    );

    dmsd_modcount u_modcount (
        .clk(clk),
        .nrst(nrst),
        .coarseCount(coarseCount),
        .fineCount(fineCount),
        .chain(chain.cnt)
    );

    // Output stage and auxiliary test selector
    logic auxOut_reg, auxOut_next;
    logic mc_reg, half_reg, div_reg;
    dmsd_aux_t auxSel;

    assign auxSel = dmsd_aux_t'(prog_reg[SEL_AUX][1:0]);

    always_comb begin
        case (auxSel)
            AUX_REF: auxOut_next = refPulse_reg;
            AUX_PRES: auxOut_next = chain.halfStageOut;
            AUX_COMP: auxOut_next = chain.compPulse;
            AUX_MODCTL: auxOut_next = chain.modulusControl;
            default: auxOut_next = 1'b0;
        endcase
        if (!prog_reg[SEL_AUX][2]) begin
            auxOut_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            auxOut_reg <= 1'b0;
            mc_reg <= 1'b1;
            half_reg <= 1'b1;
            div_reg <= 1'b0;
        end else begin
            auxOut_reg <= auxOut_next;
            mc_reg <= chain.modulusControl;
            half_reg <= chain.halfStageOut;
            div_reg <= chain.compPulse;
        end
    end

    assign nibbleLines = latch_reg[3:0];
    assign nibbleSelect = latch_reg[6:4];
    assign nibbleStrobe = latch_reg[STROBE_BIT];
    assign modulusControl = mc_reg;
    assign halfStageOut = half_reg;
    assign refPulse = refPulse_reg;
    assign divPulse = div_reg;
    assign auxOut = auxOut_reg;

    // Helpers: oscillator edges per comparison period, reference edges
    logic [12:0] totalSeen;
    logic [7:0] refSeen;
    logic seenDiv, seenRef;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            totalSeen <= 13'h0;
            refSeen <= 8'h0;
            seenDiv <= 1'b0;
            seenRef <= 1'b0;
        end else begin
            if (chain.compPulse) begin
                totalSeen <= 13'h0;
                seenDiv <= 1'b1;
            end else if (oscEdge_reg) begin
                totalSeen <= totalSeen + 13'h1;
            end
            if (refPulse_reg) begin
                refSeen <= 8'h0;
                seenRef <= 1'b1;
            end else if (refEdge) begin
                refSeen <= refSeen + 8'h1;
            end
        end
    end

    // Helper: a period is judged only if no divisor moved inside it
    logic [7:0] coarsePrev, finePrev;
    logic cfgMoved, cfgQuiet;
    assign cfgMoved = (coarseCount != coarsePrev) || (fineCount != finePrev);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            coarsePrev <= COARSE_RST;
            finePrev <= FINE_RST;
            cfgQuiet <= 1'b0;
        end else begin
            coarsePrev <= coarseCount;
            finePrev <= fineCount;
            if (chain.compPulse || cfgMoved) begin
                cfgQuiet <= !cfgMoved;
            end
        end
    end

    a_latch_hold: assert property (@(posedge clk) disable iff (!nrst)
        !port_reg[LOAD_GATE_BIT] |=> $stable(latch_reg))
        else $error("latch changed while load gate low");
    a_strobe_load: assert property (@(posedge clk) disable iff (!nrst)
        $fell(latch_reg[STROBE_BIT]) |=> ##1
            (prog_reg[$past(latch_reg[6:4], 2)] == $past(latch_reg[3:0], 2)))
        else $error("nibble not stored on strobe fall");
    a_ref_divide: assert property (@(posedge clk) disable iff (!nrst)
        (refPulse_reg && seenRef && $stable(refDiv) && refDiv != 8'h0) |->
            (refSeen == refDiv))
        else $error("reference divider ratio wrong");
    a_total_divide: assert property (@(posedge clk) disable iff (!nrst)
        (chain.compPulse && seenDiv && cfgQuiet && $stable(coarseCount) &&
            $stable(fineCount) && !oscEdge_reg) |->
            (totalSeen == 13'(coarseCount) * 13'd50 + 13'(fineCount)))
        else $error("total divide differs from 50 coarse plus fine");
    a_aux_off: assert property (@(posedge clk) disable iff (!nrst)
        !prog_reg[SEL_AUX][2] |=> !auxOut)
        else $error("auxiliary output active while disabled");
    a_apb_answer: assert property (@(posedge clk) disable iff (!nrst)
        (psel && !penable) |=> pready ##1 !pready)
        else $error("APB answer not one cycle after setup");
endmodule : dmsd_synth_divider
`default_nettype wire

/* File: bench/dmsd_sig_src.sv */
// Oscillator and reference sources feeding the divider chain
`timescale 1ns/1ps
`default_nettype none
module dmsd_sig_src #(
    parameter int HALF = 2 // Clocks per half period, keeps edges below clk/2
) (
    input wire logic clk, // System clock
    output logic oscIn, // Oscillator level
    output logic ref10mIn // Reference level
);
    int cnt = 0;
    initial begin
        oscIn = 1'b0;
        ref10mIn = 1'b0;
    end
    // Both sources run free, as real oscillators do
    always @(posedge clk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) begin
            oscIn <= ~oscIn;
            ref10mIn <= ~ref10mIn;
        end
    end
endmodule : dmsd_sig_src
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the synthesizer divider over APB
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dmsd_pkg::*;
    localparam int OSC_P = 4; // Clocks per oscillator period
    localparam logic [31:0] PROG_RST = {8'h00, FINE_RST, COARSE_RST,
        REF_DIV_RST};
    localparam logic [31:0] PROG_NEW = 32'h00053C64;
    logic clk, nrst, psel, penable, pwrite, oscIn, ref10mIn;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, err;
    logic [3:0] nibbleLines;
    logic [2:0] nibbleSelect;
    logic nibbleStrobe, modulusControl, halfStageOut;
    logic refPulse, divPulse, auxOut;
    int errors = 0;
    int check_count = 0;
    int gapLen, falls, lows, highs, n;

    dmsd_synth_divider i_dut (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .oscIn(oscIn), .ref10mIn(ref10mIn),
        .nibbleLines(nibbleLines), .nibbleSelect(nibbleSelect),
        .nibbleStrobe(nibbleStrobe), .modulusControl(modulusControl),
        .halfStageOut(halfStageOut), .refPulse(refPulse),
        .divPulse(divPulse), .auxOut(auxOut));
    dmsd_sig_src #(.HALF(OSC_P / 2)) i_src (.clk(clk), .oscIn(oscIn),
        .ref10mIn(ref10mIn));

    task automatic conclude();
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Entered just after an edge; leaves one idle cycle behind it
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) errors++;
        @(posedge clk);
    endtask : apb

    task automatic nib(input logic [2:0] s, input logic [3:0] v);
        apb(1'b1, OFF_PORT, {23'h0, 1'b1, 1'b1, s, v});
        apb(1'b1, OFF_PORT, {23'h0, 1'b1, 1'b0, s, v});
        repeat (3) @(posedge clk);
    endtask : nib

    // Clocks from one pulse to the next, with modulus activity inside
    task automatic gap(input bit useDiv);
        logic prev;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((useDiv ? divPulse : refPulse) !== 1'b1 && n < 30000);
        gapLen = 0;
        falls = 0;
        lows = 0;
        highs = 0;
        prev = modulusControl;
        do begin
            @(posedge clk);
            gapLen++;
            if (prev === 1'b1 && modulusControl === 1'b0) falls++;
            if (modulusControl === 1'b0) lows++;
            if (halfStageOut === 1'b1) highs++;
            prev = modulusControl;
        end while ((useDiv ? divPulse : refPulse) !== 1'b1
            && gapLen < 30000);
        if (n >= 30000 || gapLen >= 30000) errors++;
    endtask : gap

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        // About 90000 clocks, well past the longest scenario
        #2250000;
        errors++;
        conclude();
    end

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        apb(1'b0, OFF_PORT, 32'h00000000);
        chk(rd, {23'h0, PORT_RST});
        apb(1'b0, OFF_PROG, 32'h00000000);
        chk(rd, PROG_RST);
        apb(1'b0, 8'h0C, 32'h00000000);
        chk({31'h0, err}, 32'h00000001);
        chk(rd, 32'h00000000);
        apb(1'b1, OFF_PROG, 32'hFFFFFFFF);
        apb(1'b0, OFF_PROG, 32'h00000000);
        chk(rd, PROG_RST);
        nib(SEL_REF_LO, 4'h4);
        nib(SEL_REF_HI, 4'h6);
        gap(1'b0);
        chk(gapLen, 100 * OSC_P);
        gap(1'b1);
        chk(gapLen, 50 * 59 * OSC_P);
        chk(falls, 0);
        nib(SEL_COARSE_LO, 4'hC);
        nib(SEL_COARSE_HI, 4'h3);
        nib(SEL_FINE_LO, 4'h5);
        nib(SEL_FINE_HI, 4'h0);
        apb(1'b0, OFF_PROG, 32'h00000000);
        chk(rd, PROG_NEW);
        gap(1'b1);
        chk(gapLen, (50 * 60 + 5) * OSC_P);
        chk(falls, 1);
        chk(lows >= 5 * 50 * OSC_P && lows <= 5 * 51 * OSC_P, 1);
        chk(highs > gapLen * 2 / 5 - 300 && highs < gapLen * 2 / 5 + 300,
            1);
        apb(1'b1, OFF_PORT, 32'h000001A5);
        @(posedge clk);
        chk({nibbleStrobe, nibbleSelect, nibbleLines}, 8'hA5);
        // Gate closed: a strobe fall here must neither pass nor store
        apb(1'b1, OFF_PORT, 32'h00000037);
        @(posedge clk);
        chk({nibbleStrobe, nibbleSelect, nibbleLines}, 8'hA5);
        apb(1'b1, OFF_PORT, 32'h00000180);
        @(posedge clk);
        chk({nibbleStrobe, nibbleSelect, nibbleLines}, 8'h80);
        apb(1'b0, OFF_LATCH, 32'h00000000);
        chk(rd & 32'h000001FF, 32'h00000180);
        apb(1'b0, OFF_PROG, 32'h00000000);
        chk(rd, PROG_NEW);
        for (int s = 0; s < 4; s++) begin
            nib(SEL_AUX, {2'b01, s[1:0]});
            n = 0;
            while (auxOut !== 1'b1 && n < 13000) begin
                @(posedge clk);
                n++;
            end
            chk({31'h0, auxOut}, 32'h00000001);
        end
        nib(SEL_AUX, 4'h3);
        n = 0;
        repeat (600) begin
            @(posedge clk);
            if (auxOut !== 1'b0) n++;
        end
        chk(n, 0);
        conclude();
    end
endmodule : testbench
`default_nettype wire
